// ### cpsp_pkg.sv
package cpsp_pkg;

    // Parallel host port widths
    localparam int HOST_ADDR_W = 6;
    localparam int HOST_DATA_W = 8;
    localparam int NUM_REGS    = 64;

    // Serial link widths
    localparam int SLAVE_ID_W  = 7;
    localparam int INDEX_W     = 8;

    // Bit count of a full serial byte
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Direction bit value that asks for a read
    localparam logic DIR_READ = 1'b1;

    // Register contents after reset
    localparam logic [7:0] REG_RESET = 8'h00;

    // Synchroniser width: scl, sda, select, hold, cs, we, re, addr, data, id
    localparam int SYNC_W = 7 + HOST_ADDR_W + HOST_DATA_W + SLAVE_ID_W;

    // Serial slave states
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ADDR_ACK  = 4'h2,
        ST_INDEX     = 4'h3,
        ST_INDEX_ACK = 4'h4,
        ST_WDATA     = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA     = 4'h7,
        ST_RDATA_ACK = 4'h8
    } cpsp_state_type;

endpackage

// ### cpsp_sync.sv
`timescale 1ns/1ps
module cpsp_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } cpsp_sync_type;

    cpsp_sync_type q_r;
    cpsp_sync_type q_nxt;

    // Two flops; the first one feeds only the second
    always_comb begin
        q_nxt        = q_r;
        q_nxt.meta   = async_in;
        q_nxt.stable = q_r.meta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign sync_out = q_r.stable;

endmodule

// ### cpsp_config_port.sv
`timescale 1ns/1ps
module cpsp_config_port (
    // Clock and reset
    input  wire logic                            CORE_CLK,
    input  wire logic                            RST,
    // Port select and latch hold
    input  wire logic                            PORT_SELECT,
    input  wire logic                            LATCH_HOLD,
    // Serial link
    input  wire logic [cpsp_pkg::SLAVE_ID_W-1:0] SLAVE_ID_STRAPS,
    input  wire logic                            SCL,
    input  wire logic                            SDA_IN,
    output logic                                 SDA_OUT,
    output logic                                 SDA_OE_N,
    // Parallel host port
    input  wire logic [cpsp_pkg::HOST_ADDR_W-1:0] HOST_ADDR,
    input  wire logic [cpsp_pkg::HOST_DATA_W-1:0] HOST_DATA_BUS_IN,
    output logic      [cpsp_pkg::HOST_DATA_W-1:0] HOST_DATA_BUS_OUT,
    output logic                                 HOST_DATA_BUS_OE_N,
    input  wire logic                            CHIP_SELECT_N,
    input  wire logic                            WRITE_STROBE_N,
    input  wire logic                            READ_STROBE_N,
    // Working latches, register k at bits 8k+7..8k
    output logic [cpsp_pkg::NUM_REGS*cpsp_pkg::HOST_DATA_W-1:0] WORKING_LATCHES
);

    typedef logic [cpsp_pkg::NUM_REGS-1:0][cpsp_pkg::HOST_DATA_W-1:0]
        cpsp_bank_type;

    typedef struct packed {
        cpsp_bank_type            regs;
        cpsp_bank_type            latch;
        cpsp_pkg::cpsp_state_type st;
        logic [3:0]               cnt;
        logic [7:0]               sh;
        logic [7:0]               tx;
        logic [cpsp_pkg::INDEX_W-1:0] idx;
        logic                     drive;
        logic                     rw;
        logic                     mack;
        logic                     scl_d;
        logic                     sda_d;
        logic [7:0]               hdata;
    } cpsp_core_type;

    cpsp_core_type q_r;
    cpsp_core_type q_nxt;

    logic [cpsp_pkg::SYNC_W-1:0]      sync_w;
    logic                             scl_s;
    logic                             sda_s;
    logic                             sel_s;
    logic                             hold_s;
    logic                             cs_n_s;
    logic                             we_n_s;
    logic                             re_n_s;
    logic [cpsp_pkg::HOST_ADDR_W-1:0] haddr_s;
    logic [cpsp_pkg::HOST_DATA_W-1:0] hdin_s;
    logic [cpsp_pkg::SLAVE_ID_W-1:0]  id_s;
    logic                             scl_rise;
    logic                             scl_fall;
    logic                             start_det;
    logic                             stop_det;
    logic                             byte_done;
    logic                             host_drive;

    // Every input pin except clock and reset passes two flops before use
    cpsp_sync #(
        .WIDTH (cpsp_pkg::SYNC_W)
    ) u_sync (
        .clk      (CORE_CLK),
        .rst      (RST),
        .async_in ({SCL, SDA_IN, PORT_SELECT, LATCH_HOLD, CHIP_SELECT_N,
                    WRITE_STROBE_N, READ_STROBE_N, HOST_ADDR,
                    HOST_DATA_BUS_IN, SLAVE_ID_STRAPS}),
        .sync_out (sync_w)
    );

    assign {scl_s, sda_s, sel_s, hold_s, cs_n_s, we_n_s, re_n_s, haddr_s,
            hdin_s, id_s} = sync_w;

    // Serial link events seen by the core clock
    assign scl_rise  = scl_s && !q_r.scl_d;
    assign scl_fall  = !scl_s && q_r.scl_d;
    assign start_det = scl_s && q_r.scl_d && q_r.sda_d && !sda_s;
    assign stop_det  = scl_s && q_r.scl_d && !q_r.sda_d && sda_s;
    assign byte_done = (q_r.cnt == cpsp_pkg::BYTE_BITS);

    // Host bus drive window
    assign host_drive = sel_s && !cs_n_s && !re_n_s && we_n_s;

    // Next state of register file, latches and serial slave
    always_comb begin
        q_nxt       = q_r;
        q_nxt.scl_d = scl_s;
        q_nxt.sda_d = sda_s;
        q_nxt.hdata = q_r.regs[haddr_s];
        // Transparent host write while port select high and chip select and write strobe low
        if (sel_s && !cs_n_s && !we_n_s) begin
            q_nxt.regs[haddr_s] = hdin_s;
        end
        if (sel_s) begin
            q_nxt.st    = cpsp_pkg::ST_IDLE;
            q_nxt.drive = 1'b0;
        end else if (start_det) begin
            q_nxt.st    = cpsp_pkg::ST_ADDR;
            q_nxt.cnt   = 4'h0;
            q_nxt.drive = 1'b0;
        end else if (stop_det) begin
            q_nxt.st    = cpsp_pkg::ST_IDLE;
            q_nxt.drive = 1'b0;
        end else if (scl_rise) begin
            // Sample bits while SCL high, msb first
            if (q_r.st == cpsp_pkg::ST_RDATA_ACK) begin
                q_nxt.mack = !sda_s;
            end else if (q_r.st != cpsp_pkg::ST_IDLE && !byte_done) begin
                q_nxt.sh  = {q_r.sh[6:0], sda_s};
                q_nxt.cnt = q_r.cnt + 4'h1;
            end
        end else if (scl_fall) begin
            unique case (q_r.st)
                cpsp_pkg::ST_IDLE: begin
                end
                cpsp_pkg::ST_ADDR: begin
                    if (byte_done) begin
                        if (q_r.sh[7:1] == id_s) begin
                            q_nxt.st    = cpsp_pkg::ST_ADDR_ACK;
                            q_nxt.drive = 1'b1;
                            q_nxt.rw    = q_r.sh[0];
                        end else begin
                            q_nxt.st = cpsp_pkg::ST_IDLE;
                        end
                    end
                end
                cpsp_pkg::ST_ADDR_ACK: begin
                    q_nxt.cnt = 4'h0;
                    if (q_r.rw == cpsp_pkg::DIR_READ) begin
                        q_nxt.st    = cpsp_pkg::ST_RDATA;
                        q_nxt.tx    = q_r.regs[q_r.idx[5:0]];
                        q_nxt.drive = !q_r.regs[q_r.idx[5:0]][7];
                    end else begin
                        q_nxt.st    = cpsp_pkg::ST_INDEX;
                        q_nxt.drive = 1'b0;
                    end
                end
                cpsp_pkg::ST_INDEX: begin
                    if (byte_done) begin
                        q_nxt.idx   = q_r.sh;
                        q_nxt.st    = cpsp_pkg::ST_INDEX_ACK;
                        q_nxt.drive = 1'b1;
                    end
                end
                cpsp_pkg::ST_WDATA: begin
                    if (byte_done) begin
                        q_nxt.regs[q_r.idx[5:0]] = q_r.sh;
                        q_nxt.idx   = q_r.idx + 8'h01;
                        q_nxt.st    = cpsp_pkg::ST_WDATA_ACK;
                        q_nxt.drive = 1'b1;
                    end
                end
                cpsp_pkg::ST_INDEX_ACK, cpsp_pkg::ST_WDATA_ACK: begin
                    q_nxt.st    = cpsp_pkg::ST_WDATA;
                    q_nxt.cnt   = 4'h0;
                    q_nxt.drive = 1'b0;
                end
                cpsp_pkg::ST_RDATA: begin
                    if (byte_done) begin
                        q_nxt.st    = cpsp_pkg::ST_RDATA_ACK;
                        q_nxt.drive = 1'b0;
                    end else begin
                        q_nxt.drive = !q_r.tx[6];
                        q_nxt.tx    = {q_r.tx[6:0], 1'b0};
                    end
                end
                cpsp_pkg::ST_RDATA_ACK: begin
                    if (q_r.mack) begin
                        q_nxt.idx   = q_r.idx + 8'h01;
                        q_nxt.tx    = q_r.regs[q_r.idx[5:0] + 6'h01];
                        q_nxt.drive = !q_r.regs[q_r.idx[5:0] + 6'h01][7];
                        q_nxt.cnt   = 4'h0;
                        q_nxt.st    = cpsp_pkg::ST_RDATA;
                    end else begin
                        q_nxt.st    = cpsp_pkg::ST_IDLE;
                        q_nxt.drive = 1'b0;
                    end
                end
                default: begin
                    q_nxt.st    = cpsp_pkg::ST_IDLE;
                    q_nxt.drive = 1'b0;
                end
            endcase
        end
        // Latches follow registers unless held
        if (!hold_s) begin
            q_nxt.latch = q_nxt.regs;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Open-drain serial data, tri-state host bus
    assign SDA_OUT            = 1'b0;
    assign SDA_OE_N           = !q_r.drive;
    assign HOST_DATA_BUS_OUT  = q_r.hdata;
    assign HOST_DATA_BUS_OE_N = !host_drive;
    assign WORKING_LATCHES    = q_r.latch;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    // Steps of the serial sequences
    sequence s_addr_end;
        q_r.st == cpsp_pkg::ST_ADDR && byte_done && scl_fall && !sel_s;
    endsequence

    sequence s_wbyte_end;
        q_r.st == cpsp_pkg::ST_WDATA && byte_done && scl_fall && !sel_s;
    endsequence

    sequence s_read_nack;
        q_r.st == cpsp_pkg::ST_RDATA_ACK && scl_fall && !q_r.mack && !sel_s;
    endsequence

    chk_port_select_serial: assert property (
        sel_s |=> SDA_OE_N && q_r.st == cpsp_pkg::ST_IDLE)
        else $error("serial port active while parallel selected");

    chk_latch_hold_frozen: assert property (
        hold_s && !$past(RST) |=> $stable(q_r.latch))
        else $error("latch changed while hold high");

    chk_latch_follow: assert property (
        !hold_s |=> q_r.latch == q_r.regs)
        else $error("latch not following register");

    chk_addr_match_ack: assert property (
        s_addr_end ##0 (q_r.sh[7:1] == id_s)
        |=> q_r.st == cpsp_pkg::ST_ADDR_ACK && !SDA_OE_N)
        else $error("matching address not acknowledged");

    chk_addr_miss_idle: assert property (
        s_addr_end ##0 (q_r.sh[7:1] != id_s)
        |=> q_r.st == cpsp_pkg::ST_IDLE && SDA_OE_N)
        else $error("foreign address acknowledged");

    chk_start_restart: assert property (
        start_det && !sel_s
        |=> q_r.st == cpsp_pkg::ST_ADDR && q_r.cnt == 4'h0)
        else $error("start not recognised");

    chk_stop_idle: assert property (
        stop_det && !sel_s |=> q_r.st == cpsp_pkg::ST_IDLE)
        else $error("stop did not return to idle");

    chk_write_index_step: assert property (
        s_wbyte_end |=> q_r.regs[$past(q_r.idx[5:0])] == $past(q_r.sh)
            && q_r.idx == $past(q_r.idx) + 8'h01)
        else $error("serial write or index step wrong");

    chk_read_nack_end: assert property (
        s_read_nack |=> q_r.st == cpsp_pkg::ST_IDLE && SDA_OE_N)
        else $error("read not ended on missing acknowledge");

    chk_host_bus_gate: assert property (
        !HOST_DATA_BUS_OE_N |-> $past(PORT_SELECT, 2)
            && !$past(CHIP_SELECT_N, 2) && !$past(READ_STROBE_N, 2)
            && $past(WRITE_STROBE_N, 2))
        else $error("host bus driven outside read window");

    chk_host_read_data: assert property (
        host_drive ##1 ($stable(haddr_s) && $stable(q_r.regs))
        |-> HOST_DATA_BUS_OUT == q_r.regs[haddr_s])
        else $error("host read returned wrong register");

    chk_sda_open_drain: assert property (
        SDA_OUT == 1'b0)
        else $error("SDA driven high");

endmodule

// ### cpsp_i2c_master.sv
`timescale 1ns/1ps
module cpsp_i2c_master (
    // Serial link lines
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    // Uneven quarters of one 125 ns period: every link edge falls on a
    // falling core clock edge, never on the design's sampling edge
    localparam realtime QA = 30.0;
    localparam realtime QB = 35.0;
    logic got;

    // Idle: clock high, data left to the pull-up
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Start or repeated start: data falls while clock high
    task automatic start();
        sda_pull = 1'b0;
        #QA scl = 1'b1;
        #QA sda_pull = 1'b1;
        #QB scl = 1'b0;
        #QA;
    endtask

    // One clock pulse, data changed only while clock low
    task automatic put(input logic b);
        sda_pull = ~b;
        #QA scl = 1'b1;
        #QA got = sda;
        #QB scl = 1'b0;
        #QA;
    endtask

    // Byte out, most significant first, then the slave's answer
    task automatic send(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) put(d[i]);
        put(1'b1);
        ack = ~got;
    endtask

    // Byte in, then our own acknowledge or refusal
    task automatic recv(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            put(1'b1);
            d[i] = got;
        end
        put(~ack);
    endtask

    // Stop: data rises while clock high, link back to idle
    task automatic stop();
        sda_pull = 1'b1;
        #QA scl = 1'b1;
        #QA sda_pull = 1'b0;
        #QB;
        #QA;
    endtask
endmodule

// ### tb_config_port_serial_parallel.sv
`timescale 1ns/1ps
module tb_config_port_serial_parallel;
    localparam logic [6:0] ID = 7'h2a;
    logic         clk  = 1'b0;
    logic         rst  = 1'b1;
    logic         sel  = 1'b0;
    logic         hold = 1'b0;
    logic         cs_n = 1'b1;
    logic         we_n = 1'b1;
    logic         re_n = 1'b1;
    logic [5:0]   addr = 6'h00;
    logic [7:0]   hdrv = 8'h00;
    logic [7:0]   dout;
    logic [7:0]   bus;
    logic         doe_n;
    logic         sda_out;
    logic         sda_oe_n;
    logic         scl;
    logic         mpull;
    logic         sda;
    logic [511:0] lat;
    int           err_total   = 0;
    int           check_count = 0;

    always #2.5 clk = ~clk;

    // Wire levels: open-drain data with pull-up, shared host bus
    assign sda = (sda_oe_n ? 1'b1 : sda_out) & ~mpull;
    assign bus = doe_n ? hdrv : dout;

    cpsp_config_port i_cpsp_config_port (
        .CORE_CLK           (clk),
        .RST                (rst),
        .PORT_SELECT        (sel),
        .LATCH_HOLD         (hold),
        .SLAVE_ID_STRAPS    (ID),
        .SCL                (scl),
        .SDA_IN             (sda),
        .SDA_OUT            (sda_out),
        .SDA_OE_N           (sda_oe_n),
        .HOST_ADDR          (addr),
        .HOST_DATA_BUS_IN   (bus),
        .HOST_DATA_BUS_OUT  (dout),
        .HOST_DATA_BUS_OE_N (doe_n),
        .CHIP_SELECT_N      (cs_n),
        .WRITE_STROBE_N     (we_n),
        .READ_STROBE_N      (re_n),
        .WORKING_LATCHES    (lat)
    );

    cpsp_i2c_master i_cpsp_i2c_master (
        .scl      (scl),
        .sda_pull (mpull),
        .sda      (sda)
    );

    // Verdict and end of run
    task automatic final_report();
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Byte comparison
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    function automatic logic [7:0] latch(input int k);
        return lat[8*k +: 8];
    endfunction

    // Serial byte out with expected acknowledge
    task automatic sb(input logic [7:0] d, input logic e, input string n);
        logic a;
        i_cpsp_i2c_master.send(d, a);
        chk(n, {7'h00, e}, {7'h00, a});
    endtask

    // Parallel write; bus must stay undriven meanwhile
    task automatic pwrite(input logic [5:0] a, input logic [7:0] d);
        cyc(1);
        addr = a;
        cs_n = 1'b0;
        hdrv = d;
        cyc(1);
        we_n = 1'b0;
        cyc(4);
        chk("oe_n in write", 8'h01, {7'h00, doe_n});
        we_n = 1'b1;
        cyc(1);
        cs_n = 1'b1;
        hdrv = ~d;
        cyc(4);
    endtask

    // Parallel read with strobes released afterwards
    task automatic pread(input logic [5:0] a, input logic [7:0] e);
        cyc(1);
        addr = a;
        cs_n = 1'b0;
        re_n = 1'b0;
        cyc(5);
        chk("oe_n in read", 8'h00, {7'h00, doe_n});
        chk("read data", e, bus);
        re_n = 1'b1;
        cs_n = 1'b1;
        cyc(4);
    endtask

    // Serial burst write, parallel refused while serial selected
    task automatic t_ser_write();
        pwrite(6'h06, 8'h77);
        chk("latch 6", 8'h00, latch(6));
        i_cpsp_i2c_master.start();
        sb({ID, 1'b0}, 1'b1, "addr ack");
        sb(8'h03, 1'b1, "index ack");
        sb(8'ha5, 1'b1, "data ack");
        sb(8'h3c, 1'b1, "data ack");
        i_cpsp_i2c_master.stop();
        cyc(10);
        chk("latch 3", 8'ha5, latch(3));
        chk("latch 4", 8'h3c, latch(4));
    endtask

    // Serial burst read ended by refusal
    task automatic t_ser_read();
        logic [7:0] d;
        i_cpsp_i2c_master.start();
        sb({ID, 1'b0}, 1'b1, "addr ack");
        sb(8'h03, 1'b1, "index ack");
        i_cpsp_i2c_master.start();
        sb({ID, 1'b1}, 1'b1, "read addr ack");
        i_cpsp_i2c_master.recv(1'b1, d);
        chk("read byte 0", 8'ha5, d);
        i_cpsp_i2c_master.recv(1'b0, d);
        chk("read byte 1", 8'h3c, d);
        cyc(4);
        chk("sda released", 8'h01, {7'h00, sda_oe_n});
        i_cpsp_i2c_master.stop();
        cyc(10);
    endtask

    // Foreign id, then serial while parallel is selected
    task automatic t_ser_refused();
        i_cpsp_i2c_master.start();
        sb({ID ^ 7'h01, 1'b0}, 1'b0, "foreign ack");
        sb(8'h03, 1'b0, "ignored index");
        i_cpsp_i2c_master.stop();
        sel = 1'b1;
        cyc(4);
        i_cpsp_i2c_master.start();
        sb({ID, 1'b0}, 1'b0, "serial off");
        i_cpsp_i2c_master.stop();
        cyc(10);
    endtask

    // Held latch 5 loaded on release, register read back while held
    task automatic t_hold();
        hold = 1'b1;
        pwrite(6'h05, 8'h5a);
        chk("latch 5 held", 8'h00, latch(5));
        pread(6'h05, 8'h5a);
        hold = 1'b0;
        cyc(5);
        chk("latch 5 loaded", 8'h5a, latch(5));
    endtask

    // Read strobe tied low, write strobe as direction
    task automatic t_tied();
        re_n = 1'b0;
        pwrite(6'h3f, 8'hc3);
        cs_n = 1'b0;
        cyc(5);
        chk("tied read", 8'hc3, bus);
        cs_n = 1'b1;
        cyc(4);
        chk("oe_n idle", 8'h01, {7'h00, doe_n});
        re_n = 1'b1;
    endtask

    // Main sequence
    initial begin
        cyc(6);
        rst = 1'b0;
        cyc(3);
        t_ser_write();
        t_ser_read();
        t_ser_refused();
        t_hold();
        t_tied();
        final_report();
    end
endmodule
